/* bucket_alarm.v */
`timescale 1ns/1ps
`default_nettype none
`include "bucket_alarm_map.vh"

// What this block does
// - Raise the alarm when the accumulator reaches the set limit.
// - Clear a raised alarm once the accumulator has fallen to the clear limit.
// - Both limit registers are fully readable and writable with no side effect.
// - Add one per bad cycle and subtract one per 1, 2, 4 or 8 clean cycles by decay rate.
// - The limit pair applies only to inputs assigned to configuration 3.
// - Each input is judged once per 128 ms bucket cycle.
// - Decay code 00, 01, 10, 11 means one decrement per 128, 256, 512, 1024 ms.
module bucket_alarm #(
   parameter N_INPUTS = 4,
   parameter CYCLE_CLKS = `BUCKET_CYCLE_CLKS
) (
   // Clock and reset
   input wire clock,
   input wire arst_n,
   // Register port
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_ff,
   // Input monitor
   input wire [N_INPUTS-1:0] input_bad,
   input wire [N_INPUTS-1:0] input_in_cfg3,
   // Alarms
   output reg [N_INPUTS-1:0] alarm_ff,
   output reg cycle_tick_ff
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   // Reset takes hold at once, but its release is retimed through two flops.
   // This way no flop leaves reset on an edge that is too close to the release.
   reg rst_meta_ff;
   reg rst_n_ff;
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [7:0] set_limit_ff;
   reg [7:0] clear_limit_ff;
   reg [`DECAY_FIELD_MSB:0] decay_rate_ff;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire hit_set;
   wire hit_clear;
   wire hit_decay;
   assign hit_set = (reg_addr == `SET_LIMIT_CFG3_ADDR);
   assign hit_clear = (reg_addr == `CLEAR_LIMIT_CFG3_ADDR);
   assign hit_decay = (reg_addr == `DECAY_RATE_CFG3_ADDR);

   // Plain store
   // A write to any other address is dropped without a trace.
   always @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         set_limit_ff <= `SET_LIMIT_CFG3_RST;
         clear_limit_ff <= `CLEAR_LIMIT_CFG3_RST;
         decay_rate_ff <= `DECAY_RATE_CFG3_RST;
      end else if (reg_wr) begin
         if (hit_set) begin
            set_limit_ff <= reg_wdata;
         end
         if (hit_clear) begin
            clear_limit_ff <= reg_wdata;
         end
         if (hit_decay) begin
            decay_rate_ff <= reg_wdata[`DECAY_FIELD_MSB:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read back
   // ----------------------------------------------------------------
   // Read back
   // Reading has no side effect, so software may poll the limits freely.
   reg [7:0] nxt_rdata;
   always @* begin
      case (reg_addr)
         `SET_LIMIT_CFG3_ADDR: nxt_rdata = set_limit_ff;
         `CLEAR_LIMIT_CFG3_ADDR: nxt_rdata = clear_limit_ff;
         `DECAY_RATE_CFG3_ADDR: nxt_rdata = {6'h00, decay_rate_ff};
         default: nxt_rdata = 8'h00;
      endcase
   end

   always @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_ff <= nxt_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Bucket cycle timebase
   // ----------------------------------------------------------------
   // The counter is wide enough for the full span at 100 MHz.
   // A much shorter CYCLE_CLKS is only meant to speed up simulation.
   reg [31:0] tick_cnt_ff;
   wire tick_end;
   assign tick_end = (tick_cnt_ff == CYCLE_CLKS - 1);

   always @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         tick_cnt_ff <= 32'h0000_0000;
         cycle_tick_ff <= 1'b0;
      end else if (tick_end) begin
         tick_cnt_ff <= 32'h0000_0000;
         cycle_tick_ff <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
         cycle_tick_ff <= 1'b0;
      end
   end

   reg [3:0] decay_span;
   always @* begin
      case (decay_rate_ff)
         2'h0: decay_span = 4'h1;
         2'h1: decay_span = 4'h2;
         2'h2: decay_span = 4'h4;
         default: decay_span = 4'h8;
      endcase
   end

   // ----------------------------------------------------------------
   // Per-input buckets
   // ----------------------------------------------------------------
   // Bad inputs are sampled on the tick; the monitor must hold its verdict then.
   // The accumulator saturates at both ends, so a long outage cannot wrap round
   // to zero and silently drop the alarm.
   genvar i;
   generate
      for (i = 0; i < N_INPUTS; i = i + 1) begin : g_bucket
         reg [7:0] acc_ff;
         reg [3:0] clean_ff;
         reg [7:0] nxt_acc;
         reg [3:0] nxt_clean;
         reg nxt_alarm;
         wire leak_due;
         wire at_set;
         wire at_clear;

         assign leak_due = ((clean_ff + 4'h1) >= decay_span);

         always @* begin
            nxt_acc = acc_ff;
            if (input_bad[i]) begin
               if (acc_ff != 8'hFF) begin
                  nxt_acc = acc_ff + 8'h01;
               end
            end else if (leak_due && acc_ff != 8'h00) begin
               nxt_acc = acc_ff - 8'h01;
            end
         end

         always @* begin
            if (input_bad[i] || leak_due) begin
               nxt_clean = 4'h0;
            end else begin
               nxt_clean = clean_ff + 4'h1;
            end
         end

         assign at_set = (nxt_acc >= set_limit_ff);
         assign at_clear = (nxt_acc <= clear_limit_ff);

         // Hysteresis between limits
         // Set wins when software lets the limits overlap, so a bad input is never hidden.
         always @* begin
            if (at_set) begin
               nxt_alarm = 1'b1;
            end else if (at_clear) begin
               nxt_alarm = 1'b0;
            end else begin
               nxt_alarm = alarm_ff[i];
            end
         end

         always @(posedge clock or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
               acc_ff <= 8'h00;
               clean_ff <= 4'h0;
               alarm_ff[i] <= 1'b0;
            end else if (!input_in_cfg3[i]) begin
               acc_ff <= 8'h00;
               clean_ff <= 4'h0;
               alarm_ff[i] <= 1'b0;
            end else if (cycle_tick_ff) begin
               acc_ff <= nxt_acc;
               clean_ff <= nxt_clean;
               alarm_ff[i] <= nxt_alarm;
            end
         end
      end
   endgenerate

endmodule // bucket_alarm

`default_nettype wire

/* bucket_alarm_map.vh */
`ifndef BUCKET_ALARM_MAP_VH
`define BUCKET_ALARM_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SET_LIMIT_CFG3_ADDR 8'h5C
`define CLEAR_LIMIT_CFG3_ADDR 8'h5D
`define DECAY_RATE_CFG3_ADDR 8'h5F

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define SET_LIMIT_CFG3_RST 8'h06
`define CLEAR_LIMIT_CFG3_RST 8'h04
`define DECAY_RATE_CFG3_RST 2'h1
`define DECAY_FIELD_MSB 1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_HZ 100000000
`define BUCKET_CYCLE_MS 128
`define BUCKET_CYCLE_CLKS ((`CLOCK_HZ / 1000) * `BUCKET_CYCLE_MS)

`endif

/* bucket_alarm_props.sv */
`timescale 1ns/1ps
`default_nettype none
module bucket_alarm_props #(parameter N_INPUTS = 4, parameter CYCLE_CLKS = 12800000) (
   // Clock and registers
   input wire logic clock,
   input wire logic arst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_ff,
   // Monitor
   input wire logic [N_INPUTS-1:0] input_bad,
   input wire logic [N_INPUTS-1:0] input_in_cfg3,
   input wire logic [N_INPUTS-1:0] alarm_ff,
   input wire logic cycle_tick_ff
);
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [7:0] set_ff;
   logic [7:0] run_ff;
   logic [31:0] gap_ff;
   logic seen_ff;
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gap_ff <= 32'h0000_0000;
         seen_ff <= 1'b0;
      end else if (cycle_tick_ff) begin
         gap_ff <= 32'h0000_0001;
         seen_ff <= 1'b1;
      end else begin
         gap_ff <= gap_ff + 32'h0000_0001;
      end
   end
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         set_ff <= 8'h06;
         run_ff <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == 8'h5C) set_ff <= reg_wdata;
         if (!input_in_cfg3[0]) run_ff <= 8'h00;
         else if (cycle_tick_ff) run_ff <= input_bad[0] ? run_ff + 8'h01 : 8'h00;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   AST_TICK: assert property (cycle_tick_ff && seen_ff |-> gap_ff == CYCLE_CLKS)
      else $error("tick period wrong");
   AST_RAISE: assert property (cycle_tick_ff && input_bad[0] && input_in_cfg3[0] && !reg_wr
      && run_ff + 8'h01 >= set_ff |=> alarm_ff[0]) else $error("alarm not raised");
   AST_HOLD: assert property ($changed(alarm_ff[0]) && $past(input_in_cfg3[0]) |-> $past(cycle_tick_ff))
      else $error("alarm moved off tick");
   AST_RISE: assert property ($rose(alarm_ff[0]) |-> $past(input_bad[0])) else $error("rise without bad");
   AST_FALL: assert property ($fell(alarm_ff[0]) && $past(input_in_cfg3[0]) |-> !$past(input_bad[0]))
      else $error("clear on bad tick");
   AST_CFG: assert property (!input_in_cfg3[N_INPUTS-1] ##1 !input_in_cfg3[N_INPUTS-1]
      |-> !alarm_ff[N_INPUTS-1]) else $error("alarm outside cfg3");
   AST_RDLAT: assert property (reg_wr && reg_addr == 8'h5C ##1 reg_rd && reg_addr == 8'h5C
      |=> reg_rdata_ff == $past(reg_wdata, 2)) else $error("readback wrong");
   AST_RDHOLD: assert property (!reg_rd |=> $stable(reg_rdata_ff)) else $error("read data moved");
   cover property ($rose(alarm_ff[0]));
   cover property ($fell(alarm_ff[0]));
   cover property (reg_wr ##1 reg_rd);
endmodule // bucket_alarm_props
bind bucket_alarm bucket_alarm_props #(.N_INPUTS(N_INPUTS), .CYCLE_CLKS(CYCLE_CLKS)) u_props (.clock(clock),
   .arst_n(arst_n),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
   .input_bad(input_bad), .input_in_cfg3(input_in_cfg3), .alarm_ff(alarm_ff), .cycle_tick_ff(cycle_tick_ff));
`default_nettype wire

/* bucket_alarm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bucket_alarm_tb;
   // ----------------------------------------
   // Bench
   // ----------------------------------------
   logic clock = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [3:0] input_bad = 4'h0, input_in_cfg3 = 4'h7;
   wire [7:0] reg_rdata_ff;
   wire [3:0] alarm_ff;
   wire cycle_tick_ff;
   int num_errors = 0, checks_done = 0, p;
   // Short cycle keeps the decay loop quick.
   bucket_alarm #(.N_INPUTS(4), .CYCLE_CLKS(8)) u_dut (.clock(clock), .arst_n(arst_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .input_bad(input_bad), .input_in_cfg3(input_in_cfg3), .alarm_ff(alarm_ff), .cycle_tick_ff(cycle_tick_ff));
   initial begin
      forever #5 clock = ~clock;
   end
   task cyc;
      @(posedge clock) #1;
   endtask
   task cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("errors=%0d checks=%0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // A write is always followed by a read, so no strobe is set twice in one step.
   task wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      cyc;
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc;
      reg_rd <= 1'b0;
      cyc;
      cmp(reg_rdata_ff, e);
   endtask
   task tk(input logic [3:0] b, input int n);
      repeat (n) begin
         input_bad <= b;
         do cyc; while (cycle_tick_ff !== 1'b1);
         cyc;
      end
   endtask
   task t_tick;
      int n;
      n = 0;
      do cyc; while (cycle_tick_ff !== 1'b1);
      do begin cyc; n++; end while (cycle_tick_ff !== 1'b1);
      cmp(n[7:0], 8'h08);
   endtask
   task t_cfg;
      tk(4'hF, 3);
      cmp({4'h0, alarm_ff}, 8'h07);
      input_in_cfg3 <= 4'h6;
      cyc;
      cmp({4'h0, alarm_ff}, 8'h06);
      input_in_cfg3 <= 4'h7;
      input_bad <= 4'h0;
      cyc;
   endtask
   task t_reset;
      arst_n = 1'b0;
      cyc;
      cmp({4'h0, alarm_ff}, 8'h00);
      arst_n = 1'b1;
      repeat (3) cyc;
      rd(8'h5C, 8'h06);
      rd(8'h5D, 8'h04);
   endtask
   task t_regs;
      rd(8'h5C, 8'h06);
      rd(8'h5D, 8'h04);
      rd(8'h5F, 8'h01);
      wr(8'h10, 8'hA5);
      rd(8'h10, 8'h00);
      wr(8'h5C, 8'hAA);
      rd(8'h5C, 8'hAA);
      wr(8'h5D, 8'h55);
      rd(8'h5D, 8'h55);
      wr(8'h5C, 8'h03);
      rd(8'h5C, 8'h03);
      wr(8'h5D, 8'h01);
      rd(8'h5D, 8'h01);
   endtask
   task t_decay;
      for (int d = 0; d < 4; d++) begin
         p = 1 << d;
         wr(8'h5F, d[7:0]);
         rd(8'h5F, d[7:0]);
         tk(4'hF, 2);
         cmp({4'h0, alarm_ff}, 8'h00);
         tk(4'hF, 1);
         cmp({4'h0, alarm_ff}, 8'h07);
         tk(4'h0, 2 * p - 1);
         cmp({4'h0, alarm_ff}, 8'h07);
         tk(4'h0, 1);
         cmp({4'h0, alarm_ff}, 8'h00);
         tk(4'h0, p);
      end
   endtask
   initial begin
      repeat (3) @(posedge clock);
      #1 arst_n = 1'b1;
      repeat (3) cyc;
      t_regs;
      t_tick;
      t_decay;
      t_cfg;
      t_reset;
      final_report;
   end
   initial begin
      #50000;
      num_errors++;
      final_report;
   end
endmodule // bucket_alarm_tb
`default_nettype wire
